// File: core/eccp_mode_and_pwm_control.sv
`include "eccp_map.svh"
`default_nettype none

module eccp_mode_and_pwm_control (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic [15:0] TIMEBASE_VALUE,
  input  wire logic        PWM_SCHEDULED,
  input  wire logic        CAPTURE_PIN,
  input  wire logic        SHUTDOWN_PIN,
  output logic             COMPARE_OUT,
  output logic             COMPARE_OE_N,
  output logic             SPECIAL_EVENT,
  output logic             TIMEBASE_RESET,
  output logic             PWM_OUT_A,
  output logic             PWM_OUT_B,
  output logic             PWM_OUT_C,
  output logic             PWM_OUT_D,
  output logic             IRQ
);

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  logic [7:0]            ctrl_q;
  logic [7:0]            pwmc_q;
  logic [15:0]           cmpv_q;
  logic [15:0]           cap_q;
  logic [1:0]            status_q;
  logic [1:0]            status_d;
  logic [1:0]            mask_q;
  logic                  cfg_q;
  logic                  aw_have_q;
  logic                  w_have_q;
  logic [7:0]            waddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  wr_do;
  logic                  ctrl_wr;
  logic                  zero_wr;
  logic [1:0]            st_clr;
  logic [31:0]           rd_d;
  eccp_pkg::mode_t       mode;
  logic                  is_cmp;
  logic                  drives_pin;
  logic                  is_cap;
  logic                  is_pwm;
  logic                  idle;
  logic                  eq_q;
  logic                  match_ev;
  logic [2:0]            sync_q [2];
  logic [1:0]            lvl_q;
  logic [1:0]            prev_q;
  logic                  rise;
  logic                  fall;
  logic [3:0]            pre_q;
  logic                  cap_ev;
  logic                  ase_set;
  logic                  ase_auto;
  eccp_pkg::lane_t       pin_in;
  delay_if               dly ();

  function automatic logic addr_ok(input logic [7:0] a);
    return a inside {`OFS_CONTROL, `OFS_PWMCTL, `OFS_CMPVAL, `OFS_CAPVAL,
                     `OFS_STATUS, `OFS_MASK, `OFS_CONFIG};
  endfunction

  // Mode decode
  assign mode = eccp_pkg::mode_t'(ctrl_q[3:0]);

  always_comb begin
    is_cmp     = 1'b0;
    drives_pin = 1'b0;
    is_cap     = 1'b0;
    is_pwm     = 1'b0;
    idle       = 1'b0;
    unique case (mode)
      eccp_pkg::MODE_OFF, eccp_pkg::MODE_RSVD1, eccp_pkg::MODE_RSVD3: begin
        idle = 1'b1;
      end
      eccp_pkg::MODE_CMP_TOGGLE, eccp_pkg::MODE_CMP_SET, eccp_pkg::MODE_CMP_CLR: begin
        is_cmp     = 1'b1;
        drives_pin = 1'b1;
      end
      eccp_pkg::MODE_CMP_SWI, eccp_pkg::MODE_CMP_SPECIAL: begin
        is_cmp = 1'b1;
      end
      eccp_pkg::MODE_CAP_FALL, eccp_pkg::MODE_CAP_RISE,
      eccp_pkg::MODE_CAP_RISE4, eccp_pkg::MODE_CAP_RISE16: begin
        is_cap = 1'b1;
      end
      eccp_pkg::MODE_PWM_HH, eccp_pkg::MODE_PWM_HL,
      eccp_pkg::MODE_PWM_LH, eccp_pkg::MODE_PWM_LL: begin
        is_pwm = 1'b1;
      end
    endcase
  end

  // Bus write channels, address and data taken in either order
  assign wr_do   = aw_have_q & w_have_q & ~BVALID;
  assign ctrl_wr = wr_do & wstrb_q[0] & (waddr_q == `OFS_CONTROL);
  assign zero_wr = ctrl_wr & (wdata_q[7:0] == `RST_CONTROL);
  assign st_clr  = (wr_do & wstrb_q[0] & (waddr_q == `OFS_STATUS)) ? wdata_q[1:0] : 2'h0;

  always_ff @(posedge CLK) begin
    if (RST) begin
      AWREADY   <= 1'b0;
      aw_have_q <= 1'b0;
      waddr_q   <= 8'h00;
    end else if (AWVALID && AWREADY) begin
      AWREADY   <= 1'b0;
      aw_have_q <= 1'b1;
      waddr_q   <= AWADDR;
    end else if (wr_do) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !BVALID) begin
      AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      WREADY   <= 1'b0;
      w_have_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (WVALID && WREADY) begin
      WREADY   <= 1'b0;
      w_have_q <= 1'b1;
      wdata_q  <= WDATA;
      wstrb_q  <= WSTRB;
    end else if (wr_do) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !BVALID) begin
      WREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP  <= `RESP_OKAY;
    end else if (wr_do) begin
      BVALID <= 1'b1;
      BRESP  <= addr_ok(waddr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // Software registers; capture value is read only
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= `RST_CONTROL;
      pwmc_q <= `RST_PWMCTL;
      cmpv_q <= `RST_VALUE;
      mask_q <= `RST_FLAGS;
      cfg_q  <= 1'b0;
    end else if (wr_do) begin
      if (wstrb_q[0]) begin
        case (waddr_q)
          `OFS_CONTROL: ctrl_q <= wdata_q[7:0];
          `OFS_PWMCTL:  pwmc_q <= wdata_q[7:0];
          `OFS_CMPVAL:  cmpv_q[7:0] <= wdata_q[7:0];
          `OFS_MASK:    mask_q <= wdata_q[1:0];
          `OFS_CONFIG:  cfg_q <= wdata_q[0];
          default:      ;
        endcase
      end
      if (wstrb_q[1] && waddr_q == `OFS_CMPVAL) begin
        cmpv_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  // Bus read channel
  always_comb begin
    rd_d = 32'h0000_0000;
    case (ARADDR)
      `OFS_CONTROL: rd_d[7:0] = ctrl_q;
      `OFS_PWMCTL:  rd_d[7:0] = pwmc_q;
      `OFS_CMPVAL:  rd_d[15:0] = cmpv_q;
      `OFS_CAPVAL:  rd_d[15:0] = cap_q;
      `OFS_STATUS:  rd_d[1:0] = status_q;
      `OFS_MASK:    rd_d[1:0] = mask_q;
      `OFS_CONFIG:  rd_d[0] = cfg_q;
      default:      rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= `RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= rd_d;
      RRESP   <= addr_ok(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end else if (!RVALID) begin
      ARREADY <= 1'b1;
    end
  end

  // Pin synchronisers; a level counts once second and third stages agree
  assign pin_in = {SHUTDOWN_PIN, CAPTURE_PIN};

  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge CLK) begin
      if (RST) begin
        sync_q[g] <= 3'h0;
        lvl_q[g]  <= 1'b0;
        prev_q[g] <= 1'b0;
      end else begin
        sync_q[g] <= {sync_q[g][1:0], pin_in[g]};
        prev_q[g] <= lvl_q[g];
        if (sync_q[g][1] == sync_q[g][2]) begin
          lvl_q[g] <= sync_q[g][2];
        end
      end
    end
  end

  assign rise = lvl_q[0] & ~prev_q[0];
  assign fall = ~lvl_q[0] & prev_q[0];

  // Compare: one event per entry into equality, so a held timebase flags once
  assign match_ev = is_cmp & (TIMEBASE_VALUE == cmpv_q) & ~eq_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      eq_q <= 1'b0;
    end else begin
      eq_q <= is_cmp & (TIMEBASE_VALUE == cmpv_q);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || idle || zero_wr) begin
      COMPARE_OUT <= 1'b0;
    end else if (match_ev) begin
      if (mode == eccp_pkg::MODE_CMP_TOGGLE) begin
        COMPARE_OUT <= ~COMPARE_OUT;
      end else if (mode == eccp_pkg::MODE_CMP_SET) begin
        COMPARE_OUT <= 1'b1;
      end else if (mode == eccp_pkg::MODE_CMP_CLR) begin
        COMPARE_OUT <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      COMPARE_OE_N   <= 1'b1;
      SPECIAL_EVENT  <= 1'b0;
      TIMEBASE_RESET <= 1'b0;
    end else begin
      COMPARE_OE_N   <= ~drives_pin;
      SPECIAL_EVENT  <= match_ev & (mode == eccp_pkg::MODE_CMP_SPECIAL);
      TIMEBASE_RESET <= match_ev & (mode == eccp_pkg::MODE_CMP_SPECIAL);
    end
  end

  // Capture with edge prescaler, cleared on any mode write
  assign cap_ev = is_cap & (
    (mode == eccp_pkg::MODE_CAP_FALL & fall) |
    (mode == eccp_pkg::MODE_CAP_RISE & rise) |
    (mode == eccp_pkg::MODE_CAP_RISE4 & rise & pre_q[1:0] == `PRE_FOUR) |
    (mode == eccp_pkg::MODE_CAP_RISE16 & rise & pre_q == `PRE_SIXTEEN));

  always_ff @(posedge CLK) begin
    if (RST || idle || ctrl_wr) begin
      pre_q <= 4'h0;
    end else if (is_cap && rise) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cap_q <= `RST_VALUE;
    end else if (cap_ev) begin
      cap_q <= TIMEBASE_VALUE;
    end
  end

  // Sticky status, hardware set wins over software clear
  assign ase_set  = is_pwm & lvl_q[1];
  assign ase_auto = pwmc_q[`BIT_RESTART] & ~lvl_q[1];

  always_comb begin
    status_d[`ST_MATCH]    = match_ev | cap_ev |
                             (status_q[`ST_MATCH] & ~st_clr[`ST_MATCH]);
    status_d[`ST_SHUTDOWN] = ase_set | (status_q[`ST_SHUTDOWN] &
                             ~(st_clr[`ST_SHUTDOWN] | ase_auto | idle));
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      status_q <= `RST_FLAGS;
      IRQ      <= 1'b0;
    end else begin
      status_q <= status_d;
      IRQ      <= |(status_q & mask_q);
    end
  end

  // PWM: lanes held idle during shutdown so the delay restarts clean
  assign dly.lane_in = (is_pwm && !status_q[`ST_SHUTDOWN]) ?
                       {~PWM_SCHEDULED, PWM_SCHEDULED} : 2'b00;
  assign dly.count   = pwmc_q[`DLY_MSB:0];

  dead_delay u_delay (
    .clk (CLK),
    .rst (RST),
    .dly (dly.delay)
  );

  always_ff @(posedge CLK) begin
    if (RST || !is_pwm) begin
      PWM_OUT_A <= 1'b0;
      PWM_OUT_B <= 1'b0;
      PWM_OUT_C <= 1'b0;
      PWM_OUT_D <= 1'b0;
    end else begin
      PWM_OUT_A <= dly.lane_out[0] ^ ctrl_q[1];
      PWM_OUT_B <= dly.lane_out[1] ^ ctrl_q[0];
      PWM_OUT_C <= cfg_q & (dly.lane_out[0] ^ ctrl_q[1]);
      PWM_OUT_D <= cfg_q & (dly.lane_out[1] ^ ctrl_q[0]);
    end
  end

  a_swi_pin_free: assert property (
    (mode == eccp_pkg::MODE_CMP_SWI) |=> COMPARE_OE_N)
    else $error("pin driven in software interrupt mode");
  a_off_state_clear: assert property (
    idle |=> !COMPARE_OUT && pre_q == 4'h0)
    else $error("state not reset in off mode");
  a_toggle_on_match: assert property (
    (match_ev && mode == eccp_pkg::MODE_CMP_TOGGLE && !zero_wr)
    |=> COMPARE_OUT != $past(COMPARE_OUT))
    else $error("toggle missing on match");
  a_capture_latch: assert property (
    cap_ev |=> cap_q == $past(TIMEBASE_VALUE) && status_q[`ST_MATCH])
    else $error("capture value or flag wrong");
  a_cap16_skip: assert property (
    (mode == eccp_pkg::MODE_CAP_RISE16 && pre_q != 4'hf) |-> !cap_ev)
    else $error("capture before sixteenth edge");
  a_set_on_match: assert property (
    (match_ev && mode == eccp_pkg::MODE_CMP_SET && !zero_wr)
    |=> COMPARE_OUT && status_q[`ST_MATCH])
    else $error("set mode did not drive high");
  a_clear_on_match: assert property (
    (match_ev && mode == eccp_pkg::MODE_CMP_CLR) |=> !COMPARE_OUT && status_q[`ST_MATCH])
    else $error("clear mode did not drive low");
  a_special_trigger: assert property (
    (match_ev && mode == eccp_pkg::MODE_CMP_SPECIAL && !zero_wr)
    |=> TIMEBASE_RESET && SPECIAL_EVENT && $stable(COMPARE_OUT))
    else $error("special trigger missing");
  a_half_polarity: assert property (
    (is_pwm && $stable(ctrl_q)) |=> PWM_OUT_A == ($past(dly.lane_out[0]) ^ $past(ctrl_q[1])))
    else $error("output A polarity wrong");
  a_full_pairing: assert property (
    (is_pwm && cfg_q) |=> PWM_OUT_C == PWM_OUT_A && PWM_OUT_D == PWM_OUT_B)
    else $error("full bridge pairs differ");
  a_auto_restart: assert property (
    (status_q[`ST_SHUTDOWN] && pwmc_q[`BIT_RESTART] && !lvl_q[1]) |=> !status_q[`ST_SHUTDOWN])
    else $error("shutdown status not auto cleared");
  a_shutdown_hold: assert property (
    (status_q[`ST_SHUTDOWN] && !pwmc_q[`BIT_RESTART] && !st_clr[`ST_SHUTDOWN] && !idle)
    |=> status_q[`ST_SHUTDOWN])
    else $error("shutdown status dropped without software");
  a_match_flag: assert property (
    match_ev |=> status_q[`ST_MATCH])
    else $error("match flag not set");
  a_zero_write_low: assert property (
    zero_wr |=> !COMPARE_OUT ##1 !COMPARE_OUT)
    else $error("compare latch not cleared");
  a_reserved_quiet: assert property (
    (idle && !status_q[`ST_MATCH]) |=> !status_q[`ST_MATCH] && !TIMEBASE_RESET)
    else $error("activity in reserved mode");

  c_toggle_match: cover property (match_ev && mode == eccp_pkg::MODE_CMP_TOGGLE);
  c_capture16: cover property (cap_ev && mode == eccp_pkg::MODE_CAP_RISE16);
  c_auto_restart: cover property ($fell(status_q[`ST_SHUTDOWN]) && pwmc_q[`BIT_RESTART]);
  c_special: cover property (TIMEBASE_RESET);

endmodule // eccp_mode_and_pwm_control

`default_nettype wire

// File: core/eccp_map.svh
`ifndef ECCP_MAP_SVH
`define ECCP_MAP_SVH

`define OFS_CONTROL  8'h00
`define OFS_PWMCTL   8'h04
`define OFS_CMPVAL   8'h08
`define OFS_CAPVAL   8'h0c
`define OFS_STATUS   8'h10
`define OFS_MASK     8'h14
`define OFS_CONFIG   8'h18

`define RST_CONTROL  8'h00
`define RST_PWMCTL   8'h00
`define RST_VALUE    16'h0000
`define RST_FLAGS    2'h0

`define BIT_RESTART  7
`define DLY_MSB      6
`define ST_MATCH     0
`define ST_SHUTDOWN  1

`define PRE_FOUR     2'h3
`define PRE_SIXTEEN  4'hf

`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// File: core/eccp_pkg.sv
`default_nettype none

package eccp_pkg;

  typedef enum logic [3:0] {
    MODE_OFF         = 4'b0000,
    MODE_RSVD1       = 4'b0001,
    MODE_CMP_TOGGLE  = 4'b0010,
    MODE_RSVD3       = 4'b0011,
    MODE_CAP_FALL    = 4'b0100,
    MODE_CAP_RISE    = 4'b0101,
    MODE_CAP_RISE4   = 4'b0110,
    MODE_CAP_RISE16  = 4'b0111,
    MODE_CMP_SET     = 4'b1000,
    MODE_CMP_CLR     = 4'b1001,
    MODE_CMP_SWI     = 4'b1010,
    MODE_CMP_SPECIAL = 4'b1011,
    MODE_PWM_HH      = 4'b1100,
    MODE_PWM_HL      = 4'b1101,
    MODE_PWM_LH      = 4'b1110,
    MODE_PWM_LL      = 4'b1111
  } mode_t;

  typedef logic [1:0] lane_t;

endpackage

`default_nettype wire

// File: core/delay_if.sv
`include "eccp_map.svh"
`default_nettype none

interface delay_if;
  eccp_pkg::lane_t        lane_in;
  logic [`DLY_MSB:0]      count;
  eccp_pkg::lane_t        lane_out;

  modport ctrl (output lane_in, output count, input lane_out);
  modport delay (input lane_in, input count, output lane_out);
endinterface

`default_nettype wire

// File: core/dead_delay.sv
`include "eccp_map.svh"
`default_nettype none

module dead_delay (
  input wire logic clk,
  input wire logic rst,
  delay_if.delay   dly
);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic [`DLY_MSB:0] cnt_q [2];
  eccp_pkg::lane_t   out_q;

  assign dly.lane_out = out_q;

  // Falling edges pass at once, only the active edge waits
  for (genvar g = 0; g < 2; g++) begin : g_lane
    always_ff @(posedge clk) begin
      if (rst || !dly.lane_in[g]) begin
        cnt_q[g] <= 7'h00;
        out_q[g] <= 1'b0;
      end else begin
        if (cnt_q[g] < dly.count) begin
          cnt_q[g] <= cnt_q[g] + 7'h01;
        end
        // Held once active, so a new count mid-pulse cannot chop it
        out_q[g] <= out_q[g] | (cnt_q[g] >= dly.count);
      end
    end

    a_delay_early: assert property (
      ($rose(dly.lane_in[g]) && dly.count == 7'd2) |=> !out_q[g])
      else $error("lane active before delay count");
    a_delay_rise: assert property (
      ($rose(dly.lane_in[g]) && dly.count == 7'd2 ##1 dly.lane_in[g] [*2]) |=> out_q[g])
      else $error("lane not active after delay count");
  end

endmodule // dead_delay

`default_nettype wire

// File: testbench/bridge_side.sv
`default_nettype none

// Timebase counter that sits beside the block, as the power stage sees it
module bridge_side (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tb_reset,
  input  wire logic        run,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  output logic      [15:0] count
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] count_q;

  // Steps once per block clock, never from a faster or unrelated source
  always_ff @(posedge clk) begin
    if (rst)
      count_q <= 16'h0000;
    else if (load)
      count_q <= load_val;
    else if (tb_reset)
      count_q <= 16'h0000;
    else if (run)
      count_q <= count_q + 16'h0001;
  end

  assign count = count_q;
endmodule // bridge_side

`default_nettype wire

// File: testbench/tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        CLK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, CAPTURE_PIN, SHUTDOWN_PIN;
  logic        PWM_SCHEDULED, COMPARE_OUT, COMPARE_OE_N, SPECIAL_EVENT, TIMEBASE_RESET;
  logic        IRQ, PWM_OUT_A, PWM_OUT_B, PWM_OUT_C, PWM_OUT_D, run, load, msk;
  logic [7:0]  AWADDR, ARADDR;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic [31:0] WDATA, RDATA, rdat;
  logic [15:0] TIMEBASE_VALUE, load_val;
  int          bad_count, checked, se_n, st_n;
  logic [3:0]  ms [12] = '{4'h8, 4'h0, 4'h2, 4'h2, 4'h8, 4'h9, 4'ha, 4'h8, 4'hb, 4'h0, 4'h1, 4'h3};
  logic [2:0]  es [12] = '{3'h5, 3'h2, 3'h5, 3'h1, 3'h5, 3'h1, 3'h3, 3'h5, 3'h7, 3'h2, 3'h2, 3'h2};

  eccp_mode_and_pwm_control i_dut (
    .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .TIMEBASE_VALUE(TIMEBASE_VALUE), .PWM_SCHEDULED(PWM_SCHEDULED),
    .CAPTURE_PIN(CAPTURE_PIN), .SHUTDOWN_PIN(SHUTDOWN_PIN), .COMPARE_OUT(COMPARE_OUT),
    .COMPARE_OE_N(COMPARE_OE_N), .SPECIAL_EVENT(SPECIAL_EVENT),
    .TIMEBASE_RESET(TIMEBASE_RESET), .PWM_OUT_A(PWM_OUT_A), .PWM_OUT_B(PWM_OUT_B),
    .PWM_OUT_C(PWM_OUT_C), .PWM_OUT_D(PWM_OUT_D), .IRQ(IRQ));

  bridge_side i_bridge (
    .clk(CLK), .rst(RST), .tb_reset(TIMEBASE_RESET), .run(run), .load(load),
    .load_val(load_val), .count(TIMEBASE_VALUE));

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  // Pulses counted at the falling edge, away from the launching edge
  always @(negedge CLK) begin
    if (SPECIAL_EVENT === 1'b1) se_n++;
    if (SPECIAL_EVENT === 1'b1 && TIMEBASE_RESET === 1'b1) st_n++;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // Handshakes judged at the falling edge: nothing moves until the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, b;
    logic [1:0] r;
    int n;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    n = 0;
    do begin
      @(negedge CLK);
      ta = AWVALID & AWREADY;
      tw = WVALID & WREADY;
      b = BVALID;
      r = BRESP;
      n++;
      @(posedge CLK);
      if (ta) AWVALID <= 1'b0;
      if (tw) WVALID <= 1'b0;
    end while (b !== 1'b1 && n < 100);
    BREADY <= 1'b0;
    if (b !== 1'b1) bad_count++;
    chk(r, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    logic ta, b;
    logic [1:0] r;
    int n;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    n = 0;
    do begin
      @(negedge CLK);
      ta = ARVALID & ARREADY;
      b = RVALID;
      r = RRESP;
      rdat = RDATA;
      n++;
      @(posedge CLK);
      if (ta) ARVALID <= 1'b0;
    end while (b !== 1'b1 && n < 100);
    RREADY <= 1'b0;
    if (b !== 1'b1) bad_count++;
    chk(r, er);
  endtask

  task automatic pins(input logic [3:0] e);
    @(negedge CLK);
    chk({PWM_OUT_D, PWM_OUT_C, PWM_OUT_B, PWM_OUT_A}, e);
  endtask

  task automatic lvl(input logic v);
    @(posedge CLK);
    CAPTURE_PIN <= v;
    cyc(8);
  endtask

  task automatic sd(input logic v);
    @(posedge CLK);
    SHUTDOWN_PIN <= v;
    cyc(8);
  endtask

  task automatic t_regs;
    rd(8'h00, 2'h0);
    chk(rdat, 32'h0000_0000);
    rd(8'h04, 2'h0);
    chk(rdat, 32'h0000_0000);
    wr(8'h04, 32'hffff_ffff, 2'h0);
    rd(8'h04, 2'h0);
    chk(rdat, 32'h0000_00ff);
    wr(8'h1c, 32'h0000_0001, 2'h2);
    rd(8'h1c, 2'h2);
    chk(rdat, 32'h0000_0000);
    wr(8'h04, 32'h0000_0000, 2'h0);
    @(negedge CLK);
    chk(COMPARE_OE_N, 1'b1);
  endtask

  // e = {latch level, pin released, flag}
  task automatic cmp_case(input logic [3:0] m, input logic [2:0] e);
    @(posedge CLK);
    run <= 1'b0;
    wr(8'h00, {28'h000_0000, m}, 2'h0);
    wr(8'h10, 32'h0000_0003, 2'h0);
    @(negedge CLK);
    @(negedge CLK);
    chk(IRQ, 1'b0);
    @(posedge CLK);
    load <= 1'b1;
    load_val <= 16'h000c;
    @(posedge CLK);
    load <= 1'b0;
    run <= 1'b1;
    cyc(10);
    @(negedge CLK);
    chk({COMPARE_OUT, COMPARE_OE_N}, e[2:1]);
    chk(IRQ, e[0] & msk);
    rd(8'h10, 2'h0);
    chk(rdat[0], e[0]);
  endtask

  task automatic t_cmp;
    msk = 1'b1;
    wr(8'h14, 32'h0000_0001, 2'h0);
    wr(8'h08, 32'h0000_0010, 2'h0);
    for (int i = 0; i < 12; i++) begin
      if (i == 7) begin
        msk = 1'b0;
        wr(8'h14, 32'h0000_0000, 2'h0);
      end
      se_n = 0;
      st_n = 0;
      cmp_case(ms[i], es[i]);
      if (i == 8) begin
        chk(se_n, 1);
        chk(st_n, 1);
        chk(TIMEBASE_VALUE < 16'h0010, 1'b1);
      end
    end
  endtask

  task automatic cap_case(input logic [3:0] m, input int n);
    // Frozen timebase with a per-mode value, so a stale capture shows
    @(posedge CLK);
    run <= 1'b0;
    load <= 1'b1;
    load_val <= {12'h0a5, m};
    @(posedge CLK);
    load <= 1'b0;
    lvl(1'b0);
    wr(8'h00, {28'h000_0000, m}, 2'h0);
    wr(8'h10, 32'h0000_0003, 2'h0);
    repeat (n - 1) begin
      lvl(1'b1);
      lvl(1'b0);
    end
    rd(8'h10, 2'h0);
    chk(rdat[0], 1'b0);
    lvl(1'b1);
    if (m == 4'h4) begin
      rd(8'h10, 2'h0);
      chk(rdat[0], 1'b0);
      lvl(1'b0);
    end
    rd(8'h10, 2'h0);
    chk(rdat[0], 1'b1);
    rd(8'h0c, 2'h0);
    chk(rdat, {16'h0000, 12'h0a5, m});
  endtask

  // Dead time seen as the gap between output fall and output rise latencies
  task automatic edge_a(input logic v, output int n);
    @(posedge CLK);
    PWM_SCHEDULED <= v;
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (PWM_OUT_A !== v && n < 300);
  endtask

  task automatic dly(input int n);
    int l0, l1;
    wr(8'h04, 32'(n), 2'h0);
    edge_a(1'b0, l0);
    cyc(140);
    edge_a(1'b1, l1);
    chk(l1 - l0, n);
  endtask

  task automatic t_pwm;
    wr(8'h18, 32'h0000_0001, 2'h0);
    PWM_SCHEDULED <= 1'b1;
    for (int m = 12; m < 16; m++) begin
      wr(8'h00, 32'(m), 2'h0);
      cyc(4);
      pins({m[0], ~m[1], m[0], ~m[1]});
    end
    wr(8'h18, 32'h0000_0000, 2'h0);
    pins(4'b0010);
    wr(8'h00, 32'h0000_000c, 2'h0);
    dly(3);
    dly(2);
    dly(127);
  endtask

  task automatic t_sd;
    wr(8'h04, 32'h0000_0000, 2'h0);
    sd(1'b1);
    rd(8'h10, 2'h0);
    chk(rdat[1], 1'b1);
    pins(4'b0000);
    sd(1'b0);
    rd(8'h10, 2'h0);
    chk(rdat[1], 1'b1);
    pins(4'b0000);
    wr(8'h10, 32'h0000_0002, 2'h0);
    cyc(4);
    pins(4'b0001);
    wr(8'h04, 32'h0000_0080, 2'h0);
    sd(1'b1);
    sd(1'b0);
    rd(8'h10, 2'h0);
    chk(rdat[1], 1'b0);
    pins(4'b0001);
  endtask

  // Whole run is under two thousand cycles; this only catches a hang
  initial begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    conclude();
  end

  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, run, load} = '0;
    {CAPTURE_PIN, SHUTDOWN_PIN, PWM_SCHEDULED} = '0;
    {AWADDR, ARADDR, WDATA, load_val} = '0;
    WSTRB = 4'hf;
    bad_count = 0;
    checked = 0;
    RST = 1'b1;
    cyc(2);
    RST <= 1'b0;
    t_regs();
    t_cmp();
    cap_case(4'h4, 1);
    cap_case(4'h5, 1);
    cap_case(4'h6, 4);
    cap_case(4'h7, 16);
    t_pwm();
    t_sd();
    conclude();
  end
endmodule // tb

`default_nettype wire
